//--- design/cfg_loader.sv
// Settings commit, stored configuration restore and small command-format checks.
`timescale 1ns/10ps
`default_nettype none
module cfg_loader (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire cfg_loader_pkg::pmbus_cmd_t cmd,
	input wire cfg_loader_pkg::param_set_t staged_params,
	input wire logic outputs_on,
	input wire logic nvm_done,
	input wire cfg_loader_pkg::param_set_t nvm_params,
	input wire logic [15:0] pin_power,
	input wire logic cml_clear,
	output logic commit_pulse_ff,
	output cfg_loader_pkg::param_set_t active_params_ff,
	output logic [15:0] commit_value_ff,
	output logic nvm_req_ff,
	output logic [cfg_loader_pkg::SEL_W-1:0] nvm_sel_ff,
	output logic restore_busy_ff,
	output logic [7:0] status_cml_ff,
	output logic rsp_valid_ff,
	output logic [15:0] rsp_data_ff
);
	import cfg_loader_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Command format check shared by every handled command.

	function automatic logic fmt_ok(input pmbus_cmd_t c, input logic wr, input logic [2:0] n);
		fmt_ok = (c.is_write == wr) && (c.len == n);
	endfunction : fmt_ok

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	load_state_t state_ff;
	load_state_t nxt_state;
	logic nxt_commit_pulse;
	param_set_t nxt_active_params;
	logic [15:0] nxt_commit_value;
	logic nxt_nvm_req;
	logic [SEL_W-1:0] nxt_nvm_sel;
	logic [7:0] nxt_status_cml;
	logic nxt_rsp_valid;
	logic [15:0] nxt_rsp_data;
	logic other_fault;
	logic nxt_restore_busy;

	always_comb begin
		nxt_state = state_ff;
		nxt_commit_pulse = 1'b0;
		nxt_active_params = active_params_ff;
		nxt_commit_value = commit_value_ff;
		nxt_nvm_req = 1'b0;
		nxt_nvm_sel = nvm_sel_ff;
		nxt_status_cml = status_cml_ff;
		nxt_rsp_valid = 1'b0;
		nxt_rsp_data = rsp_data_ff;
		other_fault = 1'b0;
		if (cmd.valid) begin
			unique case (cmd.code)
				CMD_COMMIT: begin
					// Write only, two bytes; no page qualifies it.
					if (!fmt_ok(cmd, 1'b1, COMMIT_LEN) || state_ff == LD_WAIT) begin
						other_fault = 1'b1;
					end else begin
						nxt_commit_value = cmd.data;
						if (cmd.data == COMMIT_GO) begin
							// Staged raw values are taken as unsigned words.
							nxt_active_params = staged_params;
							nxt_commit_pulse = 1'b1;
						end
					end
				end
				CMD_RESTORE: begin
					// Loading under a running output is refused and flagged.
					if (!fmt_ok(cmd, 1'b1, RESTORE_LEN) || state_ff == LD_WAIT || outputs_on) begin
						other_fault = 1'b1;
					end else begin
						// Upper nibble is dropped unseen.
						nxt_nvm_sel = cmd.data[SEL_MSB:SEL_LSB];
						nxt_nvm_req = 1'b1;
						nxt_state = LD_WAIT;
					end
				end
				CMD_READ_PIN: begin
					if (!fmt_ok(cmd, 1'b0, READ_PIN_LEN)) begin
						other_fault = 1'b1;
					end else begin
						// The page selection never enters this answer.
						nxt_rsp_valid = 1'b1;
						nxt_rsp_data = pin_power;
					end
				end
				default: begin
				end
			endcase
		end
		if (state_ff == LD_WAIT && nvm_done) begin
			// Restored values go live and are rescaled like a commit.
			nxt_active_params = nvm_params;
			nxt_commit_pulse = 1'b1;
			nxt_state = LD_IDLE;
		end
		// A new fault in the clearing cycle keeps the bit set.
		if (other_fault) begin
			nxt_status_cml[CML_OTHER_BIT] = 1'b1;
		end else if (cml_clear) begin
			nxt_status_cml[CML_OTHER_BIT] = 1'b0;
		end
		nxt_restore_busy = (nxt_state == LD_WAIT);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State registers.

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= LD_IDLE;
			commit_pulse_ff <= 1'b0;
			active_params_ff <= '0;
			commit_value_ff <= COMMIT_RESET;
			nvm_req_ff <= 1'b0;
			nvm_sel_ff <= '0;
			restore_busy_ff <= 1'b0;
			status_cml_ff <= CML_RESET;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			commit_pulse_ff <= nxt_commit_pulse;
			active_params_ff <= nxt_active_params;
			commit_value_ff <= nxt_commit_value;
			nvm_req_ff <= nxt_nvm_req;
			nvm_sel_ff <= nxt_nvm_sel;
			restore_busy_ff <= nxt_restore_busy;
			status_cml_ff <= nxt_status_cml;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff <= nxt_rsp_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_good_commit;
		cmd.valid && cmd.code == CMD_COMMIT && cmd.is_write && cmd.len == COMMIT_LEN
			&& cmd.data == COMMIT_GO && !restore_busy_ff;
	endsequence

	sequence s_good_restore;
		cmd.valid && cmd.code == CMD_RESTORE && cmd.is_write && cmd.len == RESTORE_LEN
			&& !restore_busy_ff && !outputs_on;
	endsequence

	sequence s_load_done;
		restore_busy_ff && nvm_done;
	endsequence

	a_commit_adopts: assert property (s_good_commit |=> commit_pulse_ff
		&& active_params_ff == $past(staged_params))
		else $error("commit did not adopt staged parameters");

	a_commit_value_only: assert property (cmd.valid && cmd.code == CMD_COMMIT
		&& cmd.data != COMMIT_GO && !restore_busy_ff && !nvm_done |=> !commit_pulse_ff)
		else $error("commit fired on a value other than the go value");

	a_commit_read_flag: assert property (cmd.valid && cmd.code == CMD_COMMIT
		&& !cmd.is_write && !(restore_busy_ff && nvm_done)
		|=> status_cml_ff[CML_OTHER_BIT] && !commit_pulse_ff)
		else $error("read of write-only commit not flagged");

	a_restore_start: assert property (s_good_restore |=> nvm_req_ff && restore_busy_ff
		&& nvm_sel_ff == $past(cmd.data[SEL_MSB:SEL_LSB]))
		else $error("restore request or select wrong");

	a_restore_blocked: assert property (cmd.valid && cmd.code == CMD_RESTORE
		&& outputs_on |=> !nvm_req_ff && status_cml_ff[CML_OTHER_BIT])
		else $error("restore accepted while an output runs");

	a_restore_copy: assert property (s_load_done |=> !restore_busy_ff
		&& commit_pulse_ff && active_params_ff == $past(nvm_params))
		else $error("restored values not copied");

	a_busy_holds: assert property (nvm_req_ff && !nvm_done |-> restore_busy_ff
		##1 (restore_busy_ff || $past(nvm_done)))
		else $error("restore busy dropped before completion");

	a_fault_beats_clear: assert property (cmd.valid && cmd.code == CMD_READ_PIN
		&& cmd.is_write && cml_clear |=> status_cml_ff[CML_OTHER_BIT])
		else $error("clear won over a new fault");

	a_pin_global: assert property (cmd.valid && cmd.code == CMD_READ_PIN && !cmd.is_write
		&& cmd.len == READ_PIN_LEN |=> rsp_valid_ff && rsp_data_ff == $past(pin_power))
		else $error("input power answer wrong");

	// Only the catch-all fault bit of the status byte is ever used.
	localparam logic [7:0] CML_MASK = 8'(1 << CML_OTHER_BIT);

	sequence s_busy_restore;
		cmd.valid && cmd.code == CMD_RESTORE && restore_busy_ff && !nvm_done;
	endsequence

	a_restore_busy_refused: assert property (s_busy_restore
		|=> !nvm_req_ff && status_cml_ff[CML_OTHER_BIT])
		else $error("restore accepted while a load is running");

	a_req_single: assert property (nvm_req_ff |=> !nvm_req_ff)
		else $error("load request held longer than one cycle");

	a_fault_sets: assert property (other_fault |=> status_cml_ff[CML_OTHER_BIT])
		else $error("unexplained fault not flagged");

	a_clear_drops: assert property (cml_clear && !other_fault
		|=> !status_cml_ff[CML_OTHER_BIT])
		else $error("status clear did not take effect");

	a_cml_spare_zero: assert property ((status_cml_ff & ~CML_MASK) == 8'h00)
		else $error("unused status bits set");

	a_commit_stores: assert property (cmd.valid && cmd.code == CMD_COMMIT && cmd.is_write
		&& cmd.len == COMMIT_LEN && !restore_busy_ff |=> commit_value_ff == $past(cmd.data))
		else $error("commit payload not stored");

	a_pin_refused: assert property (cmd.valid && cmd.code == CMD_READ_PIN
		&& (cmd.is_write || cmd.len != READ_PIN_LEN)
		|=> !rsp_valid_ff && status_cml_ff[CML_OTHER_BIT])
		else $error("malformed input power read answered");

endmodule : cfg_loader
`default_nettype wire

//--- shared/cfg_loader_pkg.sv
// Constants and carrier types for the settings commit and configuration restore logic.
//
// Functional notes
// - Writing 01h to commit_new_parameters adopts staged parameters and requests rescaling.
// - commit_new_parameters is global, write only, two bytes, reset value 01h.
// - stored_config_loader copies the selected stored configuration into active parameters.
// - stored_config_loader is global, one byte; bits 3:0 select, bits 7:4 reserved.
// - Communication status bit 1 flags a fault that no other status bit describes.
// - Input power read is global and ignores the selected output page.
// - Setpoint, limit, droop, rate and timing payloads are unsigned integers.
package cfg_loader_pkg;

	localparam logic [7:0] CMD_COMMIT = 8'hE7;
	localparam logic [7:0] CMD_RESTORE = 8'hF2;
	localparam logic [7:0] CMD_READ_PIN = 8'h97;
	localparam logic [2:0] COMMIT_LEN = 3'h2;
	localparam logic [2:0] RESTORE_LEN = 3'h1;
	localparam logic [2:0] READ_PIN_LEN = 3'h2;
	localparam logic [15:0] COMMIT_GO = 16'h0001;
	localparam logic [15:0] COMMIT_RESET = 16'h0001;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = SEL_MSB - SEL_LSB + 1;
	localparam int CML_OTHER_BIT = 1;
	localparam logic [7:0] CML_RESET = 8'h00;
	localparam int NUM_PARAMS = 8;
	localparam int PARAM_W = 16;

	// One command as handed over by the bus protocol engine.
	typedef struct packed {
		logic valid;
		logic is_write;
		logic [7:0] code;
		logic [2:0] len;
		logic [15:0] data;
	} pmbus_cmd_t;

	// Unsigned raw values of the rescaled threshold and timing commands.
	typedef logic [NUM_PARAMS-1:0][PARAM_W-1:0] param_set_t;

	typedef enum logic [0:0] {
		LD_IDLE,
		LD_WAIT
	} load_state_t;

endpackage : cfg_loader_pkg

//--- verif/nvm_model.sv
// Behavioural store of saved configurations that answers load requests.
`timescale 1ns/10ps
`default_nettype none
module nvm_model #(
	parameter int DLY = 5
) (
	input wire logic clk_sys,
	input wire logic req,
	input wire logic [cfg_loader_pkg::SEL_W-1:0] sel,
	output logic done,
	output cfg_loader_pkg::param_set_t data
);
	import cfg_loader_pkg::*;
	// Contents are only valid in the done cycle; before the first load the bus shows all ones, after a load the inverse.
	initial begin
		done = 1'b0;
		data = '1;
		forever begin
			@(posedge clk_sys);
			if (req === 1'b1) begin
				repeat (DLY) @(posedge clk_sys);
				#1 done = 1'b1;
				for (int i = 0; i < NUM_PARAMS; i++) data[i] = {8'hC0, 4'(sel), 4'(i)};
				@(posedge clk_sys);
				#1 done = 1'b0;
				data = ~data;
			end
		end
	end
endmodule : nvm_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for settings commit, configuration restore and status checks.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import cfg_loader_pkg::*;
	logic clk_sys, rst_b, outputs_on, nvm_done, cml_clear, commit_pulse_ff, nvm_req_ff;
	logic restore_busy_ff, rsp_valid_ff;
	logic [15:0] pin_power, commit_value_ff, rsp_data_ff;
	logic [7:0] status_cml_ff;
	logic [SEL_W-1:0] nvm_sel_ff;
	pmbus_cmd_t cmd;
	param_set_t staged_params, nvm_params, active_params_ff, exp_p;
	int fail_count = 0;
	int tests_run = 0;
	logic [7:0] bad_code [6] = '{8'hE7, 8'hE7, 8'hF2, 8'hF2, 8'h97, 8'h97};
	logic bad_wr [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [2:0] bad_len [6] = '{3'h2, 3'h1, 3'h1, 3'h2, 3'h2, 3'h1};
	cfg_loader cfg_loader_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cmd(cmd),
		.staged_params(staged_params), .outputs_on(outputs_on), .nvm_done(nvm_done),
		.nvm_params(nvm_params), .pin_power(pin_power), .cml_clear(cml_clear),
		.commit_pulse_ff(commit_pulse_ff), .active_params_ff(active_params_ff),
		.commit_value_ff(commit_value_ff), .nvm_req_ff(nvm_req_ff), .nvm_sel_ff(nvm_sel_ff),
		.restore_busy_ff(restore_busy_ff), .status_cml_ff(status_cml_ff),
		.rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff));
	nvm_model nvm_model_inst (.clk_sys(clk_sys), .req(nvm_req_ff), .sel(nvm_sel_ff),
		.done(nvm_done), .data(nvm_params));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk16
	task automatic chkp(input param_set_t got, input param_set_t exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chkp
	// Called at a falling edge; outputs of the taking edge are settled on return.
	task automatic send(input logic [7:0] c, input logic w, input logic [2:0] n, input logic [15:0] d);
		cmd = '{1'b1, w, c, n, d};
		@(negedge clk_sys);
		cmd.valid = 1'b0;
	endtask : send
	task automatic clr;
		cml_clear = 1'b1;
		@(negedge clk_sys);
		cml_clear = 1'b0;
		chk16(16'(status_cml_ff), 16'h0000);
	endtask : clr
	task automatic end_sim;
		$display("tests_run %0d fail_count %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	initial begin
		#200us;
		fail_count++;
		end_sim();
	end
	initial begin
		rst_b = 1'b0;
		cmd = '0;
		outputs_on = 1'b0;
		cml_clear = 1'b0;
		pin_power = 16'h9C3E;
		for (int i = 0; i < NUM_PARAMS; i++) staged_params[i] = 16'h8000 + 16'(i * 16'h1111);
		repeat (12) @(negedge clk_sys);
		rst_b = 1'b1;
		chk16(commit_value_ff, COMMIT_RESET);
		chk16(16'(status_cml_ff), 16'h0000);
		send(CMD_COMMIT, 1'b1, COMMIT_LEN, COMMIT_GO);
		chk16(16'(commit_pulse_ff), 16'h0001);
		chkp(active_params_ff, staged_params);
		@(negedge clk_sys);
		chk16(16'(commit_pulse_ff), 16'h0000);
		send(CMD_COMMIT, 1'b1, COMMIT_LEN, 16'h0002);
		chk16(commit_value_ff, 16'h0002);
		chk16(16'(commit_pulse_ff), 16'h0000);
		$display("test commit done");
		// One idle cycle keeps two command strobes out of a single time step.
		@(negedge clk_sys);
		for (int k = 0; k < 6; k++) begin
			send(bad_code[k], bad_wr[k], bad_len[k], 16'h0001);
			chk16(16'(status_cml_ff), 16'h0002);
			chk16(16'({commit_pulse_ff, nvm_req_ff, rsp_valid_ff}), 16'h0000);
			clr();
		end
		// A fresh fault in the clearing cycle must keep the status bit set.
		@(negedge clk_sys);
		cml_clear = 1'b1;
		send(CMD_READ_PIN, 1'b1, READ_PIN_LEN, 16'h0000);
		chk16(16'(status_cml_ff), 16'h0002);
		clr();
		$display("test refusals done");
		outputs_on = 1'b1;
		send(CMD_RESTORE, 1'b1, RESTORE_LEN, 16'h00A5);
		chk16(16'({nvm_req_ff, status_cml_ff}), 16'h0002);
		clr();
		outputs_on = 1'b0;
		send(CMD_RESTORE, 1'b1, RESTORE_LEN, 16'h00A5);
		chk16(16'({nvm_req_ff, restore_busy_ff, 4'(nvm_sel_ff)}), 16'h0035);
		@(negedge clk_sys);
		send(CMD_COMMIT, 1'b1, COMMIT_LEN, COMMIT_GO);
		chk16(16'({commit_pulse_ff, status_cml_ff}), 16'h0002);
		clr();
		send(CMD_RESTORE, 1'b1, RESTORE_LEN, 16'h0007);
		chk16(16'({nvm_req_ff, status_cml_ff}), 16'h0002);
		clr();
		for (int n = 0; n < 50 && commit_pulse_ff !== 1'b1; n++) @(negedge clk_sys);
		for (int i = 0; i < NUM_PARAMS; i++) exp_p[i] = {8'hC0, 4'h5, 4'(i)};
		chkp(active_params_ff, exp_p);
		chk16(16'({commit_pulse_ff, restore_busy_ff}), 16'h0002);
		$display("test restore done");
		send(CMD_READ_PIN, 1'b0, READ_PIN_LEN, 16'h0000);
		chk16(16'(rsp_valid_ff), 16'h0001);
		chk16(rsp_data_ff, 16'h9C3E);
		$display("test read done");
		rst_b = 1'b0;
		@(negedge clk_sys);
		chk16(commit_value_ff, COMMIT_RESET);
		chk16(rsp_data_ff, 16'h0000);
		chkp(active_params_ff, '0);
		rst_b = 1'b1;
		send(CMD_COMMIT, 1'b1, COMMIT_LEN, COMMIT_GO);
		chk16(16'({commit_pulse_ff, restore_busy_ff}), 16'h0002);
		chkp(active_params_ff, staged_params);
		$display("test reset done");
		end_sim();
	end
endmodule : testbench
`default_nettype wire
